// File: core/dcim_cfg.svh
// dcim_cfg.svh: offsets, field positions and reset values for the direct-control interrupt mask block
// assumes: included by bare name by dcim_top and the testbench; the package does not include it
`ifndef DCIM_CFG_SVH
`define DCIM_CFG_SVH

// =====================================================================
// register byte offsets
`define DCIM_OFF_PSW_HI 12'h000
`define DCIM_OFF_PSW_LO 12'h004
`define DCIM_OFF_LISTEN 12'h008
`define DCIM_OFF_CTRL 12'h00c
`define DCIM_OFF_CMD 12'h010
`define DCIM_OFF_IRQ_STAT 12'h014
`define DCIM_OFF_IRQ_MASK 12'h018
`define DCIM_OFF_PEND 12'h01c
`define DCIM_OFF_GRANT 12'h020
`define DCIM_OFF_LOAD_PSW_HI 12'h024
`define DCIM_OFF_LOAD_PSW_LO 12'h028

// =====================================================================
// status word field positions (bit 0 is the msb of the 64-bit word)
`define DCIM_PSW_EXT_BIT 7
`define DCIM_PSW_MCHK_BIT 13
`define DCIM_PSW_IA_FIRST 40
`define DCIM_PSW_IA_LAST 63

// ctrl register bits
`define DCIM_CTRL_IO_CONTROL_ELEMENT_BIT 0
`define DCIM_CTRL_TEST_BIT 1
`define DCIM_CTRL_STATE_LSB 2
`define DCIM_CTRL_OWNER_LSB 4

// irq status bits
`define DCIM_IRQ_START 0
`define DCIM_IRQ_LOGOUT 1
`define DCIM_IRQ_GRANT 2
`define DCIM_IRQ_DROP 3

// =====================================================================
// reset values
`define DCIM_PSW_RST 64'h0000000000000000
`define DCIM_LISTEN_RST 4'h0
`define DCIM_CTRL_RST 8'h00

`endif

// File: core/dcim_pkg.sv
// dcim_pkg.sv: types for the direct-control interrupt mask block
// assumes: dcim_cfg.svh sits alongside
package dcim_pkg;

  // =====================================================================
  // interruption classes in grant priority order
  typedef enum logic [2:0] {
    DCIM_CLS_NONE = 3'b000,
    DCIM_CLS_MCHK = 3'b001,
    DCIM_CLS_PROG = 3'b010,
    DCIM_CLS_SVC = 3'b011,
    DCIM_CLS_EXT = 3'b100,
    DCIM_CLS_IO = 3'b101
  } dcim_class_t;

  // =====================================================================
  // start sequencer
  typedef enum logic [1:0] {
    DCIM_ST_IDLE = 2'b00,
    DCIM_ST_LOAD = 2'b01,
    DCIM_ST_RUN = 2'b10
  } dcim_state_t;

endpackage

// File: core/dcim_prio.sv
// dcim_prio.sv: fixed-priority grant over the five interruption classes
// assumes: requests already gated by the status-word masks, same clock
`timescale 1ns/1ps
module dcim_prio (
  input wire logic mchk_i,
  input wire logic prog_i,
  input wire logic svc_i,
  input wire logic ext_i,
  input wire logic io_i,
  output dcim_pkg::dcim_class_t grant_o
);
  import dcim_pkg::*;

  // =====================================================================
  // priority
  // program ranks above svc; when both are requested at once, program is granted
  always_comb begin
    if (mchk_i) begin
      grant_o = DCIM_CLS_MCHK; // see RQ11
    end else if (prog_i) begin
      grant_o = DCIM_CLS_PROG;
    end else if (svc_i) begin
      grant_o = DCIM_CLS_SVC;
    end else if (ext_i) begin
      grant_o = DCIM_CLS_EXT;
    end else if (io_i) begin
      grant_o = DCIM_CLS_IO;
    end else begin
      grant_o = DCIM_CLS_NONE;
    end
  end

endmodule

// File: core/dcim_top.sv
// dcim_top.sv: direct-control command gating and status-word interrupt masking for one computing element
// assumes: one clock, AHB-Lite slave registers, command and interrupt lines from other elements as async pins
// Functional notes
// RQ1 - an accepted external start loads the status word from location zero and starts at its bits 40 to 63.
// RQ2 - an external start from a sender whose listen bit is clear is ignored.
// RQ3 - a logout command is gated by the same sender listen bits and has no effect otherwise; in io-control-element mode only the owner field gates it.
// RQ4 - a logout is ignored while the test switch is on in configuration state zero; the code checks the switch only outside io-control-element mode.
// RQ5 - in io-control-element mode a logout is obeyed only from the one configured computing element.
// RQ6 - a maskable source is suppressed while its status-word mask bit is 0 and recognized while it is 1; io line 7 never reaches the grant here.
// RQ7 - a source without a mask position raises its interrupt unconditionally.
// RQ8 - requests are sorted into machine check, program, supervisor call, external and input/output.
// RQ9 - this element keeps its own status word and masking, untouched by other elements.
// RQ10 - a pending external interrupt is taken at instruction end only while mask bit 7 is set.
// RQ11 - simultaneous requests are granted machine check, program or svc, external, then input/output.
// RQ12 - machine check is masked by status-word bit 13.
// RQ13 - the status word holds system mask 0-7, key 8-11, mode bits 12-15, code from 20, cc and program mask 34-39.
//
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "dcim_cfg.svh"
module dcim_top #(
  parameter int SENDERS = 4
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [11:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [SENDERS-1:0] ext_start_i,
  input wire logic [SENDERS-1:0] logout_i,
  input wire logic [7:0] io_req_i,
  input wire logic mchk_req_i,
  input wire logic prog_req_i,
  input wire logic svc_req_i,
  input wire logic ext_req_i,
  input wire logic instr_end_i,
  output logic psw_load_o,
  output logic [23:0] start_addr_o,
  output logic logout_o,
  output dcim_pkg::dcim_class_t grant_class_o,
  output logic grant_o,
  output logic irq_o
);
  import dcim_pkg::*;

  // =====================================================================
  // pin synchronisers
  // command lines take three stages: two to settle the async pin, the third only to find the edge; io and level lines take two
  logic [SENDERS-1:0] start_s1_q, start_s2_q, start_s3_q;
  logic [SENDERS-1:0] logout_s1_q, logout_s2_q, logout_s3_q;
  logic [7:0] io_s1_q, io_s2_q;
  logic [3:0] lvl_s1_q, lvl_s2_q;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      start_s1_q <= '0;
      start_s2_q <= '0;
      start_s3_q <= '0;
      logout_s1_q <= '0;
      logout_s2_q <= '0;
      logout_s3_q <= '0;
      io_s1_q <= 8'h00;
      io_s2_q <= 8'h00;
      lvl_s1_q <= 4'h0;
      lvl_s2_q <= 4'h0;
    end else begin
      start_s1_q <= ext_start_i;
      start_s2_q <= start_s1_q;
      start_s3_q <= start_s2_q;
      logout_s1_q <= logout_i;
      logout_s2_q <= logout_s1_q;
      logout_s3_q <= logout_s2_q;
      io_s1_q <= io_req_i;
      io_s2_q <= io_s1_q;
      lvl_s1_q <= {mchk_req_i, prog_req_i, svc_req_i, ext_req_i};
      lvl_s2_q <= lvl_s1_q;
    end
  end

  // rising edges, taken only from the second stage onward
  logic [SENDERS-1:0] start_rise, logout_rise;
  assign start_rise = start_s2_q & ~start_s3_q;
  assign logout_rise = logout_s2_q & ~logout_s3_q;

  // =====================================================================
  // registers
  logic [63:0] psw_q;
  logic [63:0] load_psw_q;
  logic [SENDERS-1:0] listen_q;
  logic [7:0] ctrl_q;
  logic [3:0] irq_stat_q, irq_mask_q;
  logic ext_pend_q;

  logic io_mode, test_sw;
  logic [1:0] cfg_state;
  logic [1:0] owner;
  assign io_mode = ctrl_q[`DCIM_CTRL_IO_CONTROL_ELEMENT_BIT];
  assign test_sw = ctrl_q[`DCIM_CTRL_TEST_BIT];
  assign cfg_state = ctrl_q[`DCIM_CTRL_STATE_LSB +: 2];
  assign owner = ctrl_q[`DCIM_CTRL_OWNER_LSB +: 2];

  // status-word bit numbering runs msb first
  function automatic logic psw_bit(input logic [63:0] w, input int n);
    psw_bit = w[63-n];
  endfunction

  // =====================================================================
  // ahb-lite slave: zero wait states, always okay
  logic wr_pend_q;
  logic [11:0] wr_addr_q;
  logic rd_take, wr_take;
  logic word_sz;
  // only whole-word transfers are taken; a narrower one is dropped rather than half-written
  assign word_sz = (hsize_i == 3'h2);
  assign rd_take = hsel_i && hready_i && htrans_i[1] && !hwrite_i && word_sz;
  assign wr_take = hsel_i && hready_i && htrans_i[1] && hwrite_i && word_sz;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
    end else begin
      wr_pend_q <= wr_take;
      wr_addr_q <= haddr_i;
    end
  end

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction

  logic wr_cmd;
  assign wr_cmd = wr_pend_q && hit(wr_addr_q, `DCIM_OFF_CMD);

  // =====================================================================
  // command gating
  logic start_ok, logout_ok, logout_drop;
  logic [SENDERS-1:0] owner_vec;
  // an owner index past the sender count leaves no sender able to log this element out
  always_comb begin
    owner_vec = '0;
    owner_vec[owner] = 1'b1;
  end
  assign start_ok = |(start_rise & listen_q) && !io_mode; // see RQ2
  always_comb begin
    if (io_mode) begin
      logout_ok = |(logout_rise & owner_vec); // see RQ5
    end else begin
      logout_ok = |(logout_rise & listen_q) && !(test_sw && cfg_state == 2'b00); // see RQ3 see RQ4
    end
  end
  assign logout_drop = |logout_rise && !logout_ok;

  // =====================================================================
  // external start sequencer
  dcim_state_t st_q;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= DCIM_ST_IDLE;
    end else begin
      case (st_q)
        DCIM_ST_IDLE: begin
          if (start_ok) begin
            st_q <= DCIM_ST_LOAD;
          end
        end
        // a start arriving in the load cycle is dropped; senders space their commands
        DCIM_ST_LOAD: st_q <= DCIM_ST_RUN;
        DCIM_ST_RUN: begin
          if (start_ok) begin
            st_q <= DCIM_ST_LOAD;
          end
        end
        default: st_q <= DCIM_ST_IDLE;
      endcase
    end
  end

  // location-zero word lives in load_psw_q, written by the storage side over the bus
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      psw_load_o <= 1'b0;
      start_addr_o <= 24'h000000;
      logout_o <= 1'b0;
    end else begin
      psw_load_o <= (st_q == DCIM_ST_LOAD);
      if (st_q == DCIM_ST_LOAD) begin
        start_addr_o <= load_psw_q[63-`DCIM_PSW_IA_FIRST:63-`DCIM_PSW_IA_LAST]; // see RQ1
      end
      logout_o <= logout_ok;
    end
  end

  // =====================================================================
  // status word: own copy, only software or a start changes it
  // a start load wins over a bus write in the same cycle
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      psw_q <= `DCIM_PSW_RST;
    end else if (st_q == DCIM_ST_LOAD) begin
      psw_q <= load_psw_q; // see RQ1 see RQ9
    end else if (wr_pend_q && hit(wr_addr_q, `DCIM_OFF_PSW_HI)) begin
      psw_q[63:32] <= hwdata_i; // see RQ13
    end else if (wr_pend_q && hit(wr_addr_q, `DCIM_OFF_PSW_LO)) begin
      psw_q[31:0] <= hwdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      load_psw_q <= `DCIM_PSW_RST;
    end else if (wr_pend_q && hit(wr_addr_q, `DCIM_OFF_LOAD_PSW_HI)) begin
      load_psw_q[63:32] <= hwdata_i;
    end else if (wr_pend_q && hit(wr_addr_q, `DCIM_OFF_LOAD_PSW_LO)) begin
      load_psw_q[31:0] <= hwdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      listen_q <= `DCIM_LISTEN_RST;
      ctrl_q <= `DCIM_CTRL_RST;
      irq_mask_q <= 4'h0;
    end else if (wr_pend_q) begin
      if (hit(wr_addr_q, `DCIM_OFF_LISTEN)) begin
        listen_q <= hwdata_i[SENDERS-1:0];
      end else if (hit(wr_addr_q, `DCIM_OFF_CTRL)) begin
        ctrl_q <= hwdata_i[7:0];
      end else if (hit(wr_addr_q, `DCIM_OFF_IRQ_MASK)) begin
        irq_mask_q <= hwdata_i[3:0];
      end
    end
  end

  // =====================================================================
  // interruption masking and grant
  logic mchk_m, prog_m, svc_m, ext_m, io_m;
  logic [7:0] io_en;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_iomask
      assign io_en[g] = io_s2_q[g] & psw_bit(psw_q, g); // see RQ6
    end
  endgenerate
  assign mchk_m = lvl_s2_q[3] && psw_bit(psw_q, `DCIM_PSW_MCHK_BIT); // see RQ12
  assign prog_m = lvl_s2_q[2]; // see RQ7
  assign svc_m = lvl_s2_q[1];
  assign ext_m = ext_pend_q && psw_bit(psw_q, `DCIM_PSW_EXT_BIT); // see RQ10
  // io line 7 shares the external mask position, so it only shows in the pending view
  assign io_m = |io_en[6:0];

  // external requests stay pending until taken; a new arrival wins over the take
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_pend_q <= 1'b0;
    end else if (lvl_s2_q[0] || wr_cmd && hwdata_i[0]) begin
      ext_pend_q <= 1'b1;
    end else if (instr_end_i && grant_class_o == DCIM_CLS_EXT) begin
      ext_pend_q <= 1'b0; // see RQ10
    end
  end

  dcim_class_t cls;
  dcim_prio u_prio (
    .mchk_i(mchk_m),
    .prog_i(prog_m),
    .svc_i(svc_m),
    .ext_i(ext_m),
    .io_i(io_m),
    .grant_o(cls)
  ); // see RQ8 see RQ11

  // registered so the class stays steady across the instruction-end strobe
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      grant_class_o <= DCIM_CLS_NONE;
    end else begin
      grant_class_o <= cls;
    end
  end
  assign grant_o = instr_end_i && (grant_class_o != DCIM_CLS_NONE);

  // =====================================================================
  // event status, write one to clear, set wins
  logic [3:0] ev;
  assign ev = {logout_drop, grant_o, logout_ok, start_ok};
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat_q <= 4'h0;
    end else if (wr_pend_q && hit(wr_addr_q, `DCIM_OFF_IRQ_STAT)) begin
      irq_stat_q <= (irq_stat_q & ~hwdata_i[3:0]) | ev;
    end else begin
      irq_stat_q <= irq_stat_q | ev;
    end
  end
  // level built from flops only, so it cannot glitch between edges
  assign irq_o = |(irq_stat_q & irq_mask_q);

  // =====================================================================
  // read data
  // picked in the address phase: a read right behind a write to the same register
  // returns the value from before that write, so software spaces the two
  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h00000000;
    if (hit(haddr_i, `DCIM_OFF_PSW_HI)) begin
      rd_d = psw_q[63:32];
    end else if (hit(haddr_i, `DCIM_OFF_PSW_LO)) begin
      rd_d = psw_q[31:0];
    end else if (hit(haddr_i, `DCIM_OFF_LISTEN)) begin
      rd_d[SENDERS-1:0] = listen_q;
    end else if (hit(haddr_i, `DCIM_OFF_CTRL)) begin
      rd_d[7:0] = ctrl_q;
    end else if (hit(haddr_i, `DCIM_OFF_IRQ_STAT)) begin
      rd_d[3:0] = irq_stat_q;
    end else if (hit(haddr_i, `DCIM_OFF_IRQ_MASK)) begin
      rd_d[3:0] = irq_mask_q;
    end else if (hit(haddr_i, `DCIM_OFF_PEND)) begin
      rd_d[12:0] = {mchk_m, prog_m, svc_m, ext_pend_q, 1'b0, io_s2_q};
    end else if (hit(haddr_i, `DCIM_OFF_GRANT)) begin
      rd_d[4:0] = {st_q, grant_class_o};
    end else if (hit(haddr_i, `DCIM_OFF_LOAD_PSW_HI)) begin
      rd_d = load_psw_q[63:32];
    end else if (hit(haddr_i, `DCIM_OFF_LOAD_PSW_LO)) begin
      rd_d = load_psw_q[31:0];
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hrdata_o <= 32'h00000000;
    end else if (rd_take) begin
      hrdata_o <= rd_d;
    end
  end

endmodule

// File: verif/dcim_top_monitor.sv
// dcim_top_monitor.sv: port assertions for the direct-control interrupt mask block
// assumes: bound to dcim_top, one clock sys_clk_i, async reset rst_i
`timescale 1ns/1ps
module dcim_top_monitor
  import dcim_pkg::*;
#(
  parameter int SENDERS = 4
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [SENDERS-1:0] ext_start_i,
  input wire logic [SENDERS-1:0] logout_i,
  input wire logic [7:0] io_req_i,
  input wire logic mchk_req_i,
  input wire logic prog_req_i,
  input wire logic svc_req_i,
  input wire logic instr_end_i,
  input wire logic psw_load_o,
  input wire logic [23:0] start_addr_o,
  input wire logic logout_o,
  input wire dcim_pkg::dcim_class_t grant_class_o,
  input wire logic grant_o,
  input wire logic irq_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // =====================================================================
  // cycles since a command line was last high, saturating
  logic [3:0] q_st_q;
  logic [3:0] q_lo_q;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_st_q <= 4'hf;
    end else begin
      q_st_q <= (|ext_start_i) ? 4'h0 : ((q_st_q == 4'hf) ? q_st_q : q_st_q + 4'h1);
    end
  end
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_lo_q <= 4'hf;
    end else begin
      q_lo_q <= (|logout_i) ? 4'h0 : ((q_lo_q == 4'hf) ? q_lo_q : q_lo_q + 4'h1);
    end
  end

  // =====================================================================
  // assertions
  AST_START_CAUSE: assert property (psw_load_o |-> q_st_q < 4'hc)
    else $error("status word load with no recent start line");
  AST_LOGOUT_CAUSE: assert property (logout_o |-> q_lo_q < 4'hc)
    else $error("logout with no recent logout line");
  AST_LOAD_PULSE: assert property (psw_load_o |=> !psw_load_o)
    else $error("load pulse longer than one cycle");
  AST_LOGOUT_PULSE: assert property (logout_o |=> !logout_o)
    else $error("logout pulse longer than one cycle");
  AST_ADDR_HOLD: assert property (!psw_load_o |-> $stable(start_addr_o))
    else $error("start address moved without a load");
  AST_GRANT_EDGE: assert property (grant_o == (instr_end_i && grant_class_o != DCIM_CLS_NONE))
    else $error("grant not tied to instruction end");
  AST_PROG_FIRST: assert property (prog_req_i [*5] |-> grant_class_o inside {DCIM_CLS_MCHK, DCIM_CLS_PROG})
    else $error("program request lost");
  AST_SVC_ORDER: assert property ((svc_req_i && !prog_req_i) [*5]
    |-> grant_class_o inside {DCIM_CLS_MCHK, DCIM_CLS_SVC})
    else $error("svc request out of order");
  AST_IDLE_CLASS: assert property ((!mchk_req_i && !prog_req_i && !svc_req_i && io_req_i == 8'h00) [*5]
    |-> grant_class_o inside {DCIM_CLS_NONE, DCIM_CLS_EXT})
    else $error("class with no request");

  COV_LOAD: cover property (psw_load_o);
  COV_LOGOUT: cover property (logout_o);
  COV_GRANT: cover property (grant_o);
  COV_IRQ: cover property (irq_o);
endmodule

// File: verif/dcim_peer.sv
// dcim_peer.sv: model of the other elements raising direct-control command lines
// assumes: shares the block clock; lines idle low
`timescale 1ns/1ps
module dcim_peer #(
  parameter int SENDERS = 4
) (
  input wire logic sys_clk_i,
  output logic [SENDERS-1:0] ext_start_o,
  output logic [SENDERS-1:0] logout_o
);
  initial begin
    ext_start_o = '0;
    logout_o = '0;
  end
  // =====================================================================
  // one command: line high for hold cycles, then low 3 so the next edge is seen
  task automatic send(input bit lo, input int s, input int hold);
    for (int i = 0; i < hold + 3; i++) begin
      @(posedge sys_clk_i);
      if (lo) begin
        logout_o[s] <= (i < hold);
      end else begin
        ext_start_o[s] <= (i < hold);
      end
    end
  endtask
endmodule

// File: verif/tb_dcim_top.sv
// tb_dcim_top.sv: register and command tests for dcim_top
// assumes: dcim_peer and dcim_top_monitor compiled before
`timescale 1ns/1ps
`include "dcim_cfg.svh"
module tb_dcim_top;
  import dcim_pkg::*;
  logic sys_clk_i, rst_i, hsel_i, hwrite_i, hready_i, hreadyout_o, hresp_o;
  logic [11:0] haddr_i;
  logic [1:0] htrans_i;
  logic [31:0] hwdata_i, hrdata_o;
  logic [3:0] ext_start_i, logout_i;
  logic [7:0] io_req_i;
  logic [2:0] hsize_i;
  logic ext_req_i;
  logic mchk_req_i, prog_req_i, svc_req_i, instr_end_i, psw_load_o, logout_o, grant_o, irq_o;
  logic [23:0] start_addr_o;
  dcim_class_t grant_class_o;
  int n_mismatch = 0;
  int checks = 0;
  int n_load = 0;
  int n_lout = 0;
  assign hready_i = hreadyout_o;

  dcim_top #(.SENDERS(4)) dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .ext_start_i(ext_start_i),
    .logout_i(logout_i), .io_req_i(io_req_i), .mchk_req_i(mchk_req_i), .prog_req_i(prog_req_i),
    .svc_req_i(svc_req_i), .ext_req_i(ext_req_i), .instr_end_i(instr_end_i), .psw_load_o(psw_load_o),
    .start_addr_o(start_addr_o), .logout_o(logout_o), .grant_class_o(grant_class_o), .grant_o(grant_o),
    .irq_o(irq_o));
  dcim_peer #(.SENDERS(4)) peer (.sys_clk_i(sys_clk_i), .ext_start_o(ext_start_i), .logout_o(logout_i));

  initial begin
    sys_clk_i = 1'h0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    if (psw_load_o === 1'h1) n_load++;
    if (logout_o === 1'h1) n_lout++;
  end

  // =====================================================================
  // reporting
  task automatic stop_test();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic cmp32(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_cls(input dcim_class_t e);
    checks++;
    if (grant_class_o !== e) begin
      n_mismatch++;
      $display("ERROR grant class expected %h seen %h", e, grant_class_o);
    end
  endtask

  // =====================================================================
  // bus master: hold each phase until hready is sampled high
  task automatic wait_rdy();
    int k;
    k = 0;
    @(posedge sys_clk_i);
    while (hreadyout_o !== 1'h1) begin
      if (++k > 50) begin
        n_mismatch++;
        stop_test();
      end
      @(posedge sys_clk_i);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge sys_clk_i);
    hsel_i <= 1'h1;
    haddr_i <= a;
    hwrite_i <= w;
    hsize_i <= 3'h2;
    htrans_i <= 2'h2;
    wait_rdy();
    htrans_i <= 2'h0;
    hsel_i <= 1'h0;
    hwdata_i <= d;
    wait_rdy();
    r = hrdata_o;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'h1, a, d, x);
    @(posedge sys_clk_i);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
    logic [31:0] x;
    bus(1'h0, a, 32'h0, x);
    cmp32(nm, e, x);
  endtask
  // command from sender s, then count the pulses that answer it
  task automatic cmd(input bit lo, input int s, input int el, input int eo);
    int a;
    int b;
    a = n_load;
    b = n_lout;
    peer.send(lo, s, 3);
    repeat (8) @(posedge sys_clk_i);
    cmp32("load pulses", el, n_load - a);
    cmp32("logout pulses", eo, n_lout - b);
  endtask
  // levels pass two sync flops and a register before the class shows
  task automatic settle(input dcim_class_t e);
    repeat (6) @(posedge sys_clk_i);
    cmp_cls(e);
  endtask

  // =====================================================================
  // main sequence
  initial begin
    rst_i = 1'h1;
    hsel_i = 1'h0;
    hwrite_i = 1'h0;
    haddr_i = '0;
    htrans_i = '0;
    hwdata_i = '0;
    hsize_i = 3'h2;
    ext_req_i = 1'h0;
    io_req_i = '0;
    {mchk_req_i, prog_req_i, svc_req_i, instr_end_i} = '0;
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    rdc(`DCIM_OFF_PSW_HI, 32'h0, "status word hi");
    rdc(`DCIM_OFF_LISTEN, 32'h0, "listen");
    rdc(12'h3fc, 32'h0, "unmapped");
    cmp32("hresp okay", 32'h0, {31'h0, hresp_o});
    wr(`DCIM_OFF_LOAD_PSW_LO, 32'h00abcdef);
    cmd(1'h0, 1, 0, 0);
    wr(`DCIM_OFF_LISTEN, 32'h2);
    cmd(1'h0, 1, 1, 0);
    cmp32("start addr", 32'h00abcdef, {8'h0, start_addr_o});
    rdc(`DCIM_OFF_PSW_LO, 32'h00abcdef, "status word lo");
    cmd(1'h1, 2, 0, 0);
    wr(`DCIM_OFF_CTRL, 32'h2);
    cmd(1'h1, 1, 0, 0);
    wr(`DCIM_OFF_CTRL, 32'h6);
    cmd(1'h1, 1, 0, 1);
    wr(`DCIM_OFF_LISTEN, 32'hf);
    wr(`DCIM_OFF_CTRL, 32'h21);
    cmd(1'h1, 1, 0, 0);
    cmd(1'h1, 2, 0, 1);
    cmd(1'h0, 2, 0, 0);
    rdc(`DCIM_OFF_IRQ_STAT, 32'hb, "irq status");
    cmp32("irq masked", 32'h0, {31'h0, irq_o});
    wr(`DCIM_OFF_IRQ_MASK, 32'h8);
    cmp32("irq raised", 32'h1, {31'h0, irq_o});
    wr(`DCIM_OFF_IRQ_STAT, 32'h8);
    cmp32("irq cleared", 32'h0, {31'h0, irq_o});
    rdc(`DCIM_OFF_IRQ_STAT, 32'h3, "irq status");
    mchk_req_i <= 1'h1;
    prog_req_i <= 1'h1;
    io_req_i <= 8'h01;
    settle(DCIM_CLS_PROG);
    wr(`DCIM_OFF_PSW_HI, 32'h80040000);
    settle(DCIM_CLS_MCHK);
    mchk_req_i <= 1'h0;
    prog_req_i <= 1'h0;
    svc_req_i <= 1'h1;
    settle(DCIM_CLS_SVC);
    svc_req_i <= 1'h0;
    settle(DCIM_CLS_IO);
    wr(`DCIM_OFF_PSW_HI, 32'h00040000);
    settle(DCIM_CLS_NONE);
    wr(`DCIM_OFF_CMD, 32'h1);
    settle(DCIM_CLS_NONE);
    wr(`DCIM_OFF_PSW_HI, 32'h81000000);
    settle(DCIM_CLS_EXT);
    instr_end_i <= 1'h1;
    @(posedge sys_clk_i);
    instr_end_i <= 1'h0;
    cmp32("grant", 32'h1, {31'h0, grant_o});
    settle(DCIM_CLS_IO);
    rdc(`DCIM_OFF_IRQ_STAT, 32'h7, "irq status");
    ext_req_i <= 1'h1;
    settle(DCIM_CLS_EXT);
    ext_req_i <= 1'h0;
    settle(DCIM_CLS_EXT);
    rdc(`DCIM_OFF_GRANT, 32'h14, "grant reg");
    stop_test();
  end
endmodule

bind dcim_top dcim_top_monitor #(.SENDERS(SENDERS)) mon (.*);
